// *** flash_erase_control_regs.sv ***
/*
 Flash program/erase control registers behind an Avalon-MM slave with waitrequest.
 Assumes the program/erase engine, standby logic and flash array run on ref_clk;
 the write enable pin and both test select pins are asynchronous.
*/
`timescale 1ns/100ps
`default_nettype none

module flash_erase_control_regs
    import flash_ctrl_pkg::*;
#(
    parameter int AV_DW = 32,
    parameter int AV_AW = 4
) (
    input wire logic ref_clk, // 40 MHz system clock
    input wire logic rst_b, // Async reset, active low
    input wire logic clk_en, // Freezes all state when low
    input wire logic [AV_AW-1:0] avs_address, // Register index
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [AV_DW-1:0] avs_writedata, // Write data
    input wire logic [AV_DW/8-1:0] avs_byteenable, // Byte lanes
    output logic [AV_DW-1:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    input wire logic write_enable_pin, // Write enable pin, async
    input wire logic first_test_select_pin, // First test select pin, async
    input wire logic second_test_select_pin, // Second test select pin, async
    input wire logic standby_mode, // Standby entry
    input wire logic program_erase_error, // Engine error pulse
    input wire logic [flash_ctrl_pkg::FLASH_AW-1:0] flash_addr, // Target address
    output logic [flash_ctrl_pkg::NUM_BLOCKS-1:0] erase_block_enable, // Selected blocks
    output logic flash_addr_erasable, // Target block selected
    output logic erase_mode_active, // Erase mode
    output logic program_mode_active, // Program mode
    output logic erase_verify_active, // Erase-verify mode
    output logic program_verify_active, // Program-verify mode
    output logic error_protect // Error protection
);

    import flash_ctrl_pkg::*;

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (AV_DW != 32) begin : g_dw_check
        $error("Bus data width must be 32");
    end
    if (AV_AW < 4) begin : g_aw_check
        $error("Bus address needs at least 4 bits");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] pin_sync;
        logic [1:0] t1_sync;
        logic [1:0] t2_sync;
        logic sw_enable;
        logic erase_verify;
        logic program_verify;
        logic erase_mode;
        logic program_mode;
        logic error_flag;
        logic erase_setup;
        logic program_setup;
        logic [6:0] blocks;
        logic ctrl_select;
        logic ack;
        logic [7:0] rdata;
        logic addr_erasable;
    } state_t;

    state_t s_q;
    state_t s_d;

    localparam state_t STATE_RESET = '{
        pin_sync: 2'h0,
        t1_sync: 2'h0,
        t2_sync: 2'h0,
        sw_enable: 1'b0,
        erase_verify: 1'b0,
        program_verify: 1'b0,
        erase_mode: 1'b0,
        program_mode: 1'b0,
        error_flag: 1'b0,
        erase_setup: 1'b0,
        program_setup: 1'b0,
        blocks: RESET_BLOCKS,
        ctrl_select: 1'b0,
        ack: 1'b0,
        rdata: RESET_BYTE,
        addr_erasable: 1'b0
    };

    logic pin_level;
    logic test1_level;
    logic second_test_select_pin_level;
    logic request;
    logic take_write;
    logic [3:0] idx;
    logic [7:0] wbyte;
    logic flash_idx;
    logic [7:0] read_mux;

    block_map_if map ();

    erase_block_map u_map (
        .map(map.decoder)
    );

    assign map.addr = flash_addr;

    assign pin_level = s_q.pin_sync[1];
    assign test1_level = s_q.t1_sync[1];
    assign second_test_select_pin_level = s_q.t2_sync[1];
    assign request = avs_read | avs_write;
    assign idx = avs_address[3:0];
    assign wbyte = avs_writedata[7:0];
    assign take_write = avs_write & s_q.ack & avs_byteenable[0];
    assign flash_idx = (idx <= IDX_LAST_FLASH);

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    always_comb begin
        read_mux = RESET_BYTE;
        if (flash_idx && !s_q.ctrl_select) begin
            read_mux = RESET_BYTE;
        end else if (idx == IDX_MODE_ONE) begin
            read_mux[PIN_LEVEL_BIT] = pin_level;
            read_mux[SW_ENABLE_BIT] = s_q.sw_enable;
            read_mux[ERASE_VERIFY_BIT] = s_q.erase_verify;
            read_mux[PROGRAM_VERIFY_BIT] = s_q.program_verify;
            read_mux[ERASE_MODE_BIT] = s_q.erase_mode;
            read_mux[PROGRAM_MODE_BIT] = s_q.program_mode;
        end else if (idx == IDX_ERR_SETUP) begin
            read_mux[ERROR_FLAG_BIT] = s_q.error_flag;
            read_mux[ERASE_SETUP_BIT] = s_q.erase_setup;
            read_mux[PROGRAM_SETUP_BIT] = s_q.program_setup;
        end else if (idx == IDX_ERASE_BLK) begin
            read_mux = {1'b0, s_q.blocks};
        end else if (idx == IDX_MONITOR) begin
            read_mux = {6'h00, second_test_select_pin_level, test1_level};
        end else if (idx == IDX_SYS_CTRL) begin
            read_mux[CTRL_SELECT_BIT] = s_q.ctrl_select;
        end else begin
            read_mux = RESET_BYTE;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.pin_sync = {s_q.pin_sync[0], write_enable_pin};
        s_d.t1_sync = {s_q.t1_sync[0], first_test_select_pin};
        s_d.t2_sync = {s_q.t2_sync[0], second_test_select_pin};

        // One wait state, answer in the second cycle
        s_d.ack = request & ~s_q.ack;
        if (request && !s_q.ack) begin
            s_d.rdata = read_mux;
        end

        // Register writes; flash registers need select and pin enable
        if (take_write && flash_idx && s_q.ctrl_select && pin_level) begin
            if (idx == IDX_MODE_ONE) begin
                s_d.sw_enable = wbyte[SW_ENABLE_BIT];
                s_d.erase_verify = wbyte[ERASE_VERIFY_BIT] & s_q.sw_enable;
                s_d.program_verify = wbyte[PROGRAM_VERIFY_BIT] & s_q.sw_enable;
                s_d.erase_mode = wbyte[ERASE_MODE_BIT] & s_q.sw_enable & s_q.erase_setup;
                s_d.program_mode = wbyte[PROGRAM_MODE_BIT] & s_q.sw_enable & s_q.program_setup;
            end else if (idx == IDX_ERR_SETUP) begin
                s_d.erase_setup = wbyte[ERASE_SETUP_BIT] & s_q.sw_enable;
                s_d.program_setup = wbyte[PROGRAM_SETUP_BIT] & s_q.sw_enable;
            end else if (idx == IDX_ERASE_BLK) begin
                s_d.blocks = wbyte[6:0];
            end
        end
        if (take_write && idx == IDX_SYS_CTRL) begin
            s_d.ctrl_select = wbyte[CTRL_SELECT_BIT];
        end

        // Hardware protect and standby clear the mode bits
        if (standby_mode || !pin_level) begin
            s_d.sw_enable = 1'b0;
            s_d.erase_verify = 1'b0;
            s_d.program_verify = 1'b0;
            s_d.erase_mode = 1'b0;
            s_d.program_mode = 1'b0;
        end

        // Setups and block select also clear in software protect
        if (standby_mode || !pin_level || !s_d.sw_enable) begin
            s_d.erase_setup = 1'b0;
            s_d.program_setup = 1'b0;
            s_d.blocks = RESET_BLOCKS;
        end

        // Error flag is sticky; only reset clears it
        s_d.error_flag = s_q.error_flag | program_erase_error;
        if (s_d.error_flag) begin
            s_d.erase_mode = 1'b0;
            s_d.program_mode = 1'b0;
        end

        s_d.addr_erasable = |(map.onehot & s_q.blocks);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= STATE_RESET;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign avs_waitrequest = request & ~s_q.ack;
    assign avs_readdata = {{(AV_DW-8){1'b0}}, s_q.rdata};
    assign erase_block_enable = s_q.blocks;
    assign flash_addr_erasable = s_q.addr_erasable;
    assign erase_mode_active = s_q.erase_mode;
    assign program_mode_active = s_q.program_mode;
    assign erase_verify_active = s_q.erase_verify;
    assign program_verify_active = s_q.program_verify;
    assign error_protect = s_q.error_flag;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic answer_read;
    assign answer_read = avs_read & ~avs_waitrequest;

    property p_error_sets;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && program_erase_error) |=> error_protect;
    endproperty
    a_error_sets: assert property (p_error_sets) else $error("Error flag not set");

    property p_error_blocks;
        @(posedge ref_clk) disable iff (!rst_b)
        error_protect |-> (!erase_mode_active && !program_mode_active);
    endproperty
    a_error_blocks: assert property (p_error_blocks) else $error("Mode under error");

    property p_error_sticky;
        @(posedge ref_clk) disable iff (!rst_b)
        error_protect |=> error_protect [*3];
    endproperty
    a_error_sticky: assert property (p_error_sticky) else $error("Error flag cleared");

    property p_setup_reserved;
        @(posedge ref_clk) disable iff (!rst_b)
        (answer_read && idx == IDX_ERR_SETUP) |-> (avs_readdata[6:2] == 5'h00);
    endproperty
    a_setup_reserved: assert property (p_setup_reserved) else $error("Setup bits 6:2 set");

    property p_erase_setup_guard;
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(s_q.erase_setup) |-> ($past(pin_level) && $past(s_q.sw_enable));
    endproperty
    a_erase_setup_guard: assert property (p_erase_setup_guard) else $error("Bad erase setup");

    property p_prog_setup_guard;
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(s_q.program_setup) |-> ($past(pin_level) && $past(s_q.sw_enable));
    endproperty
    a_prog_setup_guard: assert property (p_prog_setup_guard) else $error("Bad prog setup");

    property p_block_top;
        @(posedge ref_clk) disable iff (!rst_b)
        (answer_read && idx == IDX_ERASE_BLK) |-> !avs_readdata[7];
    endproperty
    a_block_top: assert property (p_block_top) else $error("Block bit 7 set");

    property p_block_clear;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && (standby_mode || !pin_level)) |=> (erase_block_enable == RESET_BLOCKS);
    endproperty
    a_block_clear: assert property (p_block_clear) else $error("Blocks not cleared");

    property p_block_swe;
        @(posedge ref_clk) disable iff (!rst_b)
        !s_q.sw_enable |-> (erase_block_enable == RESET_BLOCKS);
    endproperty
    a_block_swe: assert property (p_block_swe) else $error("Blocks without enable");

    property p_monitor;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && answer_read && idx == IDX_MONITOR) |->
            (avs_readdata[7:0] == {6'h00, $past(second_test_select_pin_level), $past(test1_level)});
    endproperty
    a_monitor: assert property (p_monitor) else $error("Monitor mismatch");

    property p_sys_reserved;
        @(posedge ref_clk) disable iff (!rst_b)
        (answer_read && idx == IDX_SYS_CTRL) |-> (avs_readdata[7:0] & 8'hF7) == 8'h00;
    endproperty
    a_sys_reserved: assert property (p_sys_reserved) else $error("Sys ctrl reserved set");

    property p_unselected;
        @(posedge ref_clk) disable iff (!rst_b)
        (answer_read && flash_idx && !s_q.ctrl_select) |-> (avs_readdata == '0);
    endproperty
    a_unselected: assert property (p_unselected) else $error("Unselected reg read");

    property p_enable_needs_pin;
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(s_q.sw_enable) |-> $past(pin_level);
    endproperty
    a_enable_needs_pin: assert property (p_enable_needs_pin) else $error("Enable without pin");

    property p_setup_clear;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && (standby_mode || !pin_level)) |=> (!s_q.erase_setup && !s_q.program_setup);
    endproperty
    a_setup_clear: assert property (p_setup_clear) else $error("Setup not cleared");

endmodule : flash_erase_control_regs

`default_nettype wire

// *** flash_ctrl_pkg.sv ***
/*
 Constants shared by the flash control register block and its block map.
 Assumes a single 40 MHz system clock and word-indexed register access.
*/
`default_nettype none

package flash_ctrl_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_MODE_ONE = 4'h0;
    localparam logic [3:0] IDX_ERR_SETUP = 4'h1;
    localparam logic [3:0] IDX_ERASE_BLK = 4'h3;
    localparam logic [3:0] IDX_MONITOR = 4'h9;
    localparam logic [3:0] IDX_SYS_CTRL = 4'hF;
    localparam logic [3:0] IDX_LAST_FLASH = 4'h3;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PIN_LEVEL_BIT = 7;
    localparam int SW_ENABLE_BIT = 6;
    localparam int ERASE_VERIFY_BIT = 3;
    localparam int PROGRAM_VERIFY_BIT = 2;
    localparam int ERASE_MODE_BIT = 1;
    localparam int PROGRAM_MODE_BIT = 0;
    localparam int ERROR_FLAG_BIT = 7;
    localparam int ERASE_SETUP_BIT = 1;
    localparam int PROGRAM_SETUP_BIT = 0;
    localparam int CTRL_SELECT_BIT = 3;

    // ------------------------------------------------------------
    // Reset values and block map
    // ------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [6:0] RESET_BLOCKS = 7'h00;
    localparam int NUM_BLOCKS = 7;
    localparam int FLASH_AW = 16;
    localparam logic [6:0][15:0] BLK_FIRST = {
        16'hC000, 16'h8000, 16'h1000, 16'h0C00, 16'h0800, 16'h0400, 16'h0000
    };
    localparam logic [6:0][15:0] BLK_LAST = {
        16'hEDFF, 16'hBFFF, 16'h7FFF, 16'h0FFF, 16'h0BFF, 16'h07FF, 16'h03FF
    };

endpackage : flash_ctrl_pkg

`default_nettype wire

// *** block_map_if.sv ***
/*
 Carrier between the register block and the erase block decoder.
 Assumes both ends share the system clock domain; it is purely combinational.
*/
`timescale 1ns/100ps
`default_nettype none

interface block_map_if;
    logic [15:0] addr;
    logic [6:0] onehot;

    modport decoder (
        input addr,
        output onehot
    );

    modport user (
        output addr,
        input onehot
    );
endinterface : block_map_if

`default_nettype wire

// *** erase_block_map.sv ***
/*
 Decodes a flash array address into the one-hot erase block it falls in.
 Assumes the address is a same-clock value; outside the array no bit is set.
*/
`timescale 1ns/100ps
`default_nettype none

module erase_block_map
    import flash_ctrl_pkg::*;
(
    block_map_if.decoder map // Address in, block out
);

    // ------------------------------------------------------------
    // Range compare per block
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_BLOCKS; i++) begin
            map.onehot[i] = (map.addr >= BLK_FIRST[i]) && (map.addr <= BLK_LAST[i]);
        end
    end

endmodule : erase_block_map

`default_nettype wire

// *** testbench.sv ***
/*
 Self-checking bench for the flash program/erase control register block.
 Assumes the design files are compiled first; drives every input port itself, the registers over Avalon-MM and the pins directly.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import flash_ctrl_pkg::*;

    // --------------------------------------------------------
    // Stimulus and observed signals
    // --------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic write_enable_pin = 1'b0;
    logic first_test_select_pin = 1'b1;
    logic second_test_select_pin = 1'b0;
    logic standby_mode = 1'b0;
    logic program_erase_error = 1'b0;
    logic [15:0] flash_addr = 16'h0000;
    logic [6:0] erase_block_enable;
    logic flash_addr_erasable, erase_mode_active, program_mode_active;
    logic erase_verify_active, program_verify_active, error_protect;
    int miscompares = 0;
    int total_checks = 0;
    logic [15:0] lo [7] = '{16'h0000, 16'h0400, 16'h0800, 16'h0C00, 16'h1000, 16'h8000, 16'hC000};
    logic [15:0] hi [7] = '{16'h03FF, 16'h07FF, 16'h0BFF, 16'h0FFF, 16'h7FFF, 16'hBFFF, 16'hEDFF};

    flash_erase_control_regs dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .write_enable_pin(write_enable_pin), .first_test_select_pin(first_test_select_pin),
        .second_test_select_pin(second_test_select_pin), .standby_mode(standby_mode),
        .program_erase_error(program_erase_error), .flash_addr(flash_addr),
        .erase_block_enable(erase_block_enable), .flash_addr_erasable(flash_addr_erasable),
        .erase_mode_active(erase_mode_active), .program_mode_active(program_mode_active),
        .erase_verify_active(erase_verify_active),
        .program_verify_active(program_verify_active), .error_protect(error_protect)
    );

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    // --------------------------------------------------------
    // Checking, bus access and closing
    // --------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        if (miscompares == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    // Holds the request until waitrequest is seen low, then releases it
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, wd};
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        check("bus wait states", n, 32'd2);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
        logic [31:0] x;
        bus(1'b0, a, 8'h00, x);
        check(name, x, {24'h0, exp});
    endtask : rd

    // Ends at a falling edge so outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : tick

    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        end_of_test();
    end

    // --------------------------------------------------------
    // Test sequence
    // --------------------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        tick(3);
        rd(IDX_SYS_CTRL, 8'h00, "sys ctrl reset");
        rd(IDX_MONITOR, 8'h01, "monitor first pin");
        @(posedge ref_clk);
        first_test_select_pin <= 1'b0;
        second_test_select_pin <= 1'b1;
        write_enable_pin <= 1'b1;
        tick(3);
        wr(IDX_MONITOR, 8'hFF);
        rd(IDX_MONITOR, 8'h02, "monitor second pin");
        rd(4'h5, 8'h00, "unmapped read");
        rd(IDX_MODE_ONE, 8'h00, "mode reg unselected");
        wr(IDX_SYS_CTRL, 8'hFF);
        rd(IDX_SYS_CTRL, 8'h08, "sys ctrl reserved");
        @(posedge ref_clk);
        avs_byteenable <= 4'hE;
        wr(IDX_SYS_CTRL, 8'h00);
        @(posedge ref_clk);
        avs_byteenable <= 4'hF;
        rd(IDX_SYS_CTRL, 8'h08, "lane masked write");
        rd(IDX_MODE_ONE, 8'h80, "pin level visible");
        rd(IDX_ERR_SETUP, 8'h00, "setup reset");
        wr(IDX_ERR_SETUP, 8'h02);
        rd(IDX_ERR_SETUP, 8'h00, "setup without enable");
        wr(IDX_ERASE_BLK, 8'h01);
        rd(IDX_ERASE_BLK, 8'h00, "blocks without enable");
        wr(IDX_MODE_ONE, 8'h40);
        wr(IDX_MODE_ONE, 8'h48);
        tick(1);
        check("erase verify", erase_verify_active, 1'b1);
        wr(IDX_MODE_ONE, 8'h44);
        tick(1);
        check("program verify", program_verify_active, 1'b1);
        wr(IDX_MODE_ONE, 8'h42);
        tick(1);
        check("erase mode without setup", erase_mode_active, 1'b0);
        wr(IDX_MODE_ONE, 8'h40);
        wr(IDX_ERR_SETUP, 8'hFE);
        rd(IDX_ERR_SETUP, 8'h02, "erase setup");
        wr(IDX_MODE_ONE, 8'h42);
        tick(1);
        check("erase mode", erase_mode_active, 1'b1);
        wr(IDX_MODE_ONE, 8'h40);
        wr(IDX_ERR_SETUP, 8'h01);
        rd(IDX_ERR_SETUP, 8'h01, "program setup");
        wr(IDX_MODE_ONE, 8'h41);
        tick(1);
        check("program mode", program_mode_active, 1'b1);
        @(posedge ref_clk);
        program_erase_error <= 1'b1;
        @(posedge ref_clk);
        program_erase_error <= 1'b0;
        tick(1);
        check("error protect", error_protect, 1'b1);
        check("mode dropped on error", program_mode_active, 1'b0);
        wr(IDX_MODE_ONE, 8'h41);
        tick(1);
        check("mode blocked on error", program_mode_active, 1'b0);
        wr(IDX_ERR_SETUP, 8'h01);
        rd(IDX_ERR_SETUP, 8'h81, "error flag sticks");
        for (int i = 0; i < 7; i++) begin
            wr(IDX_ERASE_BLK, 8'h80 | (8'h01 << i));
            rd(IDX_ERASE_BLK, 8'h01 << i, "block select");
            check("block enable", erase_block_enable, 7'h01 << i);
            @(posedge ref_clk);
            flash_addr <= lo[i];
            tick(1);
            check("first address", flash_addr_erasable, 1'b1);
            @(posedge ref_clk);
            flash_addr <= hi[i];
            tick(1);
            check("last address", flash_addr_erasable, 1'b1);
            @(posedge ref_clk);
            flash_addr <= (i == 6) ? 16'hEE00 : lo[i+1];
            tick(1);
            check("protected address", flash_addr_erasable, 1'b0);
        end
        wr(IDX_SYS_CTRL, 8'h00);
        rd(IDX_ERASE_BLK, 8'h00, "blocks unselected");
        wr(IDX_ERASE_BLK, 8'h01);
        wr(IDX_SYS_CTRL, 8'h08);
        rd(IDX_ERASE_BLK, 8'h40, "blocks retained");
        @(posedge ref_clk);
        standby_mode <= 1'b1;
        @(posedge ref_clk);
        standby_mode <= 1'b0;
        rd(IDX_ERASE_BLK, 8'h00, "blocks standby");
        rd(IDX_ERR_SETUP, 8'h80, "setups standby");
        wr(IDX_MODE_ONE, 8'h40);
        wr(IDX_ERASE_BLK, 8'h02);
        tick(1);
        check("block before pin low", erase_block_enable, 7'h02);
        @(posedge ref_clk);
        write_enable_pin <= 1'b0;
        tick(4);
        check("blocks pin low", erase_block_enable, 7'h00);
        wr(IDX_MODE_ONE, 8'h40);
        rd(IDX_MODE_ONE, 8'h00, "enable needs pin");
        @(posedge ref_clk);
        write_enable_pin <= 1'b1;
        tick(4);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        tick(3);
        @(posedge ref_clk);
        rst_b <= 1'b1;
        tick(3);
        check("error cleared by reset", error_protect, 1'b0);
        rd(IDX_SYS_CTRL, 8'h00, "sys ctrl second reset");
        // Clock enable low must hold off the error flag
        @(posedge ref_clk);
        clk_en <= 1'b0;
        program_erase_error <= 1'b1;
        tick(2);
        check("frozen error flag", error_protect, 1'b0);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        tick(1);
        check("error after thaw", error_protect, 1'b1);
        @(posedge ref_clk);
        program_erase_error <= 1'b0;
        end_of_test();
    end

endmodule : testbench

`default_nettype wire
